// *** rtl/rbcp_reset_ctrl.sv ***
// Overview of operation
// - merge pin, watchdog, power-on, brownout resets
// - asserted source restarts wake-up timer
// - hold reset until pin, oscillator, count, flash
// - release fetches from address zero, boot mapped
// - peripherals held reset until core released
// - upper brownout stage raises interrupt request
// - upper stage masked elsewhere, readable in status
// - lower brownout stage forces chip reset
// - brownout reset holds until power-on takes over
// - threshold levels arrive debounced, used directly
// - flash pattern picks level, else protection off
// - firmware programming calls always granted
// - level one: no jtag, no sector zero
// - level two: no jtag, erase all then write
// - level three: no jtag, isp only after firmware re-entry, pin ignored
//
// The address map and the APB interface to the registers were decided locally.
`include "rbcp_map.svh"

module rbcp_reset_ctrl #(
  parameter int WAKE_CYCLES = `RBCP_WAKE_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // reset sources
  input  wire logic        extResetPinN,
  input  wire logic        watchdogReset,
  input  wire logic        porReset,
  input  wire logic        brownoutUpper,
  input  wire logic        brownoutLower,
  // release conditions
  input  wire logic        oscRunning,
  input  wire logic        flashInitDone,
  input  wire logic [31:0] flashProtectWord,
  input  wire logic        progEntryPinN,
  // programming requests
  input  wire logic        ispCmdValid,
  input  wire logic [3:0]  ispCmd,
  input  wire logic [7:0]  ispSector,
  input  wire logic        iapReq,
  // outputs
  output logic             coreReset,
  output logic             periphReset,
  output logic             flashInitStart,
  output logic [31:0]      bootFetchAddr,
  output logic             bootMapActive,
  output logic             brownoutIrq,
  output logic             jtagEnable,
  output logic             ispActive,
  output logic             ispGrant,
  output logic             ispDeny,
  output logic             iapGrant
);
  localparam int CW = $clog2(WAKE_CYCLES + 1);

  logic              srcAsync;      // raw merged reset source
  logic              rstHeld;       // synchronised reset hold
  logic [6:0]        pinSync;       // synchronised pin levels
  logic              extLowS;       // pin held low
  logic              wdtS;
  logic              porS;
  logic              bodUpS;
  logic              bodLowS;
  logic              oscS;
  logic              flashDoneS;
  logic              entryLowS;     // programming entry pin held low
  rbcp_pkg::rbcp_seq_t   seq_r;
  rbcp_pkg::rbcp_level_t level_r;
  rbcp_pkg::rbcp_level_t levelNxt;
  logic [CW-1:0]     wakeCnt_r;     // wake-up timer
  logic [3:0]        cause_r;       // sticky reset causes
  logic              reinvoke_r;    // firmware re-entered programming
  logic              erased_r;      // full erase seen at level two
  logic              ispOk;         // command allowed now
  logic              apbWr;
  logic              apbRd;
  logic              seqHold;

  // merged source drives the asynchronous assertion
  assign srcAsync = ~extResetPinN | watchdogReset | porReset | brownoutLower;

  rbcp_rst_sync uRstSync (
    .core_clk (core_clk),
    .srcAsync (srcAsync),
    .rstHeld  (rstHeld)
  );

  rbcp_sync #(.WIDTH(7)) uPinSync (
    .core_clk (core_clk),
    .rst      (rst),
    .asyncIn  ({~extResetPinN, watchdogReset, porReset, brownoutUpper,
                brownoutLower, oscRunning, ~progEntryPinN}),
    .syncOut  (pinSync)
  );

  // brownout levels are already hysteretic, no filter here
  assign extLowS   = pinSync[6];
  assign wdtS      = pinSync[5];
  assign porS      = pinSync[4];
  assign bodUpS    = pinSync[3];
  assign bodLowS   = pinSync[2];
  assign oscS      = pinSync[1];
  assign entryLowS = pinSync[0];

  // flash done is from a separate controller domain
  rbcp_sync #(.WIDTH(1)) uFlashSync (
    .core_clk (core_clk),
    .rst      (rst),
    .asyncIn  (flashInitDone),
    .syncOut  (flashDoneS)
  );

  assign seqHold = rst | rstHeld;
  assign apbWr   = psel & penable & pready & pwrite;
  assign apbRd   = psel & ~penable & ~pwrite;

  // protection level decode of the flash word
  always_comb
  begin
    case (flashProtectWord)
      `RBCP_PAT_ONE:   levelNxt = rbcp_pkg::PROT_ONE;
      `RBCP_PAT_TWO:   levelNxt = rbcp_pkg::PROT_TWO;
      `RBCP_PAT_THREE: levelNxt = rbcp_pkg::PROT_THREE;
      default:         levelNxt = rbcp_pkg::PROT_OFF;
    endcase
  end

  // release sequence
  always_ff @(posedge core_clk)
  begin
    if (seqHold)
    begin
      seq_r     <= rbcp_pkg::SEQ_HOLD;
      wakeCnt_r <= '0;
    end
    else
    begin
      case (seq_r)
        rbcp_pkg::SEQ_HOLD:
        begin
          // pin released and oscillator up
          if (!extLowS && oscS)
            seq_r <= rbcp_pkg::SEQ_COUNT;
        end
        rbcp_pkg::SEQ_COUNT:
        begin
          // fixed clock count
          if (wakeCnt_r == CW'(WAKE_CYCLES - 1))
            seq_r <= rbcp_pkg::SEQ_FLASH;
          wakeCnt_r <= wakeCnt_r + 1'b1;
        end
        rbcp_pkg::SEQ_FLASH:
        begin
          // flash initialisation finished
          if (flashDoneS)
            seq_r <= rbcp_pkg::SEQ_RUN;
        end
        rbcp_pkg::SEQ_RUN:
          seq_r <= rbcp_pkg::SEQ_RUN;
        default:
          seq_r <= rbcp_pkg::SEQ_HOLD;
      endcase
    end
  end

  // flash init start pulse on entry to flash wait
  always_ff @(posedge core_clk)
  begin
    if (seqHold)
      flashInitStart <= 1'b0;
    else
      flashInitStart <= (seq_r == rbcp_pkg::SEQ_COUNT)
                        && (wakeCnt_r == CW'(WAKE_CYCLES - 1));
  end

  // core reset: asserted at once, released by the sequence
  always_ff @(posedge core_clk or posedge srcAsync)
  begin
    if (srcAsync)
      coreReset <= 1'b1;
    else
      coreReset <= seqHold | (seq_r != rbcp_pkg::SEQ_RUN);
  end

  // peripherals leave reset with the core
  always_ff @(posedge core_clk or posedge srcAsync)
  begin
    if (srcAsync)
      periphReset <= 1'b1;
    else
      periphReset <= seqHold | (seq_r != rbcp_pkg::SEQ_RUN);
  end

  // fetch address and boot block mapping
  always_ff @(posedge core_clk)
  begin
    if (seqHold)
    begin
      bootFetchAddr <= `RBCP_BOOT_ADDR;
      bootMapActive <= 1'b1;
    end
    else if (apbWr && paddr == `RBCP_OFS_CTRL && pwdata[`RBCP_CTRL_UNMAP])
      bootMapActive <= 1'b0;
  end

  // protection level captured when flash is ready
  always_ff @(posedge core_clk)
  begin
    if (seqHold)
      level_r <= rbcp_pkg::PROT_OFF;
    else if (seq_r == rbcp_pkg::SEQ_FLASH && flashDoneS)
      level_r <= levelNxt;
  end

  // jtag only without protection
  always_ff @(posedge core_clk)
  begin
    if (seqHold)
      jtagEnable <= 1'b0;
    else
      jtagEnable <= (seq_r == rbcp_pkg::SEQ_RUN)
                    && (level_r == rbcp_pkg::PROT_OFF);
  end

  // firmware re-entry of the programming path
  always_ff @(posedge core_clk)
  begin
    if (seqHold)
      reinvoke_r <= 1'b0;
    else if (apbWr && paddr == `RBCP_OFS_CTRL && pwdata[`RBCP_CTRL_REINVOKE])
      reinvoke_r <= 1'b1;
  end

  // programming mode: entry pin at boot, or firmware
  always_ff @(posedge core_clk)
  begin
    if (seqHold)
      ispActive <= 1'b0;
    else if (seq_r == rbcp_pkg::SEQ_FLASH && flashDoneS)
      ispActive <= entryLowS && (levelNxt != rbcp_pkg::PROT_THREE);
    else if (reinvoke_r)
      ispActive <= 1'b1;
  end

  // command filter per protection level
  always_comb
  begin
    ispOk = 1'b0;
    case (level_r)
      rbcp_pkg::PROT_OFF:
        ispOk = 1'b1;
      rbcp_pkg::PROT_ONE:
        // limited set, sector zero untouched
        ispOk = ((ispCmd == `RBCP_CMD_WRITE || ispCmd == `RBCP_CMD_ERASE_SEC)
                 && ispSector != `RBCP_SECTOR_ZERO)
                || ispCmd == `RBCP_CMD_GO;
      rbcp_pkg::PROT_TWO:
        // full erase, then update
        ispOk = (ispCmd == `RBCP_CMD_ERASE_ALL)
                || (ispCmd == `RBCP_CMD_WRITE && erased_r);
      rbcp_pkg::PROT_THREE:
        // only after firmware re-entry
        ispOk = reinvoke_r;
      default:
        ispOk = 1'b0;
    endcase
  end

  // erase-all tracking for level two
  always_ff @(posedge core_clk)
  begin
    if (seqHold)
      erased_r <= 1'b0;
    else if (ispCmdValid && ispActive && ispOk && ispCmd == `RBCP_CMD_ERASE_ALL)
      erased_r <= 1'b1;
  end

  // grant or deny pulse per command
  always_ff @(posedge core_clk)
  begin
    if (seqHold)
    begin
      ispGrant <= 1'b0;
      ispDeny  <= 1'b0;
    end
    else
    begin
      ispGrant <= ispCmdValid && ispActive && ispOk;
      ispDeny  <= ispCmdValid && !(ispActive && ispOk);
    end
  end

  // firmware calls pass at every level
  always_ff @(posedge core_clk)
  begin
    if (seqHold)
      iapGrant <= 1'b0;
    else
      iapGrant <= iapReq;
  end

  // upper brownout stage to the interrupt controller
  always_ff @(posedge core_clk)
  begin
    if (rst)
      brownoutIrq <= 1'b0;
    else
      brownoutIrq <= bodUpS;
  end

  // sticky reset causes, set beats write-one-to-clear
  always_ff @(posedge core_clk)
  begin
    if (rst)
      cause_r <= '0;
    else
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (apbWr && paddr == `RBCP_OFS_CAUSE && pwdata[b])
          cause_r[b] <= 1'b0;
      end
      if (extLowS)
        cause_r[`RBCP_CAUSE_EXT] <= 1'b1;
      if (wdtS)
        cause_r[`RBCP_CAUSE_WDT] <= 1'b1;
      if (porS)
        cause_r[`RBCP_CAUSE_POR] <= 1'b1;
      if (bodLowS)
        cause_r[`RBCP_CAUSE_BOD] <= 1'b1;
    end
  end

  // apb ready: zero-wait, registered from the setup cycle, high in the access cycle
  always_ff @(posedge core_clk)
  begin
    if (rst)
      pready <= 1'b0;
    else
      pready <= psel & ~penable;
  end

  // apb error for unmapped offsets
  always_ff @(posedge core_clk)
  begin
    if (rst)
      pslverr <= 1'b0;
    else
      pslverr <= psel & ~penable
                 & (paddr != `RBCP_OFS_STATUS)
                 & (paddr != `RBCP_OFS_CAUSE)
                 & (paddr != `RBCP_OFS_CTRL);
  end

  // apb read data captured in the setup cycle
  always_ff @(posedge core_clk)
  begin
    if (rst)
      prdata <= '0;
    else if (apbRd)
    begin
      prdata <= '0;
      case (paddr)
        `RBCP_OFS_STATUS:
        begin
          prdata[`RBCP_ST_BOD_UPPER] <= bodUpS;
          prdata[`RBCP_ST_BOD_LOWER] <= bodLowS;
          prdata[`RBCP_ST_LEVEL_HI:`RBCP_ST_LEVEL_LO] <= level_r;
          prdata[`RBCP_ST_JTAG]      <= jtagEnable;
          prdata[`RBCP_ST_ISP]       <= ispActive;
          prdata[`RBCP_ST_BOOTMAP]   <= bootMapActive;
          prdata[`RBCP_ST_RUN]       <= (seq_r == rbcp_pkg::SEQ_RUN);
        end
        `RBCP_OFS_CAUSE:
          prdata[`RBCP_CAUSE_BOD:`RBCP_CAUSE_EXT] <= cause_r;
        `RBCP_OFS_CTRL:
          prdata[`RBCP_CTRL_REINVOKE] <= reinvoke_r;
        default:
          prdata <= '0;
      endcase
    end
  end
endmodule // rbcp_reset_ctrl

// *** include/rbcp_map.svh ***
`ifndef RBCP_MAP_SVH
`define RBCP_MAP_SVH
// apb register byte offsets
`define RBCP_ADDR_W        8
`define RBCP_OFS_STATUS    8'h00
`define RBCP_OFS_CAUSE     8'h04
`define RBCP_OFS_CTRL      8'h08
// status register fields
`define RBCP_ST_BOD_UPPER  0
`define RBCP_ST_BOD_LOWER  1
`define RBCP_ST_LEVEL_LO   2
`define RBCP_ST_LEVEL_HI   3
`define RBCP_ST_JTAG       4
`define RBCP_ST_ISP        5
`define RBCP_ST_BOOTMAP    6
`define RBCP_ST_RUN        7
// reset cause fields, write one to clear
`define RBCP_CAUSE_EXT     0
`define RBCP_CAUSE_WDT     1
`define RBCP_CAUSE_POR     2
`define RBCP_CAUSE_BOD     3
// control fields
`define RBCP_CTRL_REINVOKE 0
`define RBCP_CTRL_UNMAP    1
// protection patterns held in the flash word
`define RBCP_PAT_ONE       32'h12345678
`define RBCP_PAT_TWO       32'h87654321
`define RBCP_PAT_THREE     32'h43218765
// programming commands
`define RBCP_CMD_READ      4'h0
`define RBCP_CMD_WRITE     4'h1
`define RBCP_CMD_ERASE_SEC 4'h2
`define RBCP_CMD_ERASE_ALL 4'h3
`define RBCP_CMD_GO        4'h4
// sequencing constants
`define RBCP_WAKE_CYCLES   256
`define RBCP_BOOT_ADDR     32'h00000000
`define RBCP_SECTOR_ZERO   8'h00
`endif

// *** include/rbcp_pkg.sv ***
package rbcp_pkg;
  // reset release sequence
  typedef enum logic [2:0] {
    SEQ_HOLD,
    SEQ_COUNT,
    SEQ_FLASH,
    SEQ_RUN
  } rbcp_seq_t;
  // code read protection level
  typedef enum logic [1:0] {
    PROT_OFF,
    PROT_ONE,
    PROT_TWO,
    PROT_THREE
  } rbcp_level_t;
endpackage

// *** rtl/rbcp_sync.sv ***
// two flip-flop level synchroniser, one lane per bit
module rbcp_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta_r; // first stage, read only by second

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : gLane
      // per bit double register
      always_ff @(posedge core_clk)
      begin
        if (rst)
        begin
          meta_r[i]  <= 1'b0;
          syncOut[i] <= 1'b0;
        end
        else
        begin
          meta_r[i]  <= asyncIn[i];
          syncOut[i] <= meta_r[i];
        end
      end
    end
  endgenerate
endmodule // rbcp_sync

// *** rtl/rbcp_rst_sync.sv ***
// reset hold: asserts at once, releases two edges after the source drops
module rbcp_rst_sync (
  input  wire logic core_clk,
  input  wire logic srcAsync,
  output logic      rstHeld
);
  logic stage_r; // first stage, read only by second

  // asynchronous set, synchronous release
  always_ff @(posedge core_clk or posedge srcAsync)
  begin
    if (srcAsync)
    begin
      stage_r <= 1'b1;
      rstHeld <= 1'b1;
    end
    else
    begin
      stage_r <= 1'b0;
      rstHeld <= stage_r;
    end
  end
endmodule // rbcp_rst_sync

// *** bench/rbcp_flash_model.sv ***
// flash controller and oscillator standing beside the reset sequencer
module rbcp_flash_model #(
  parameter int DELAY = 3
) (
  input  wire logic        core_clk,
  input  wire logic        srcAny,
  input  wire logic        flashInitStart,
  input  wire logic [31:0] protWord,
  output logic             oscRunning = 1'b0,
  output logic             flashInitDone = 1'b0,
  output logic [31:0]      flashProtectWord
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;  // edges left in flash init
  // oscillator settles one edge after every source drops
  always_ff @(posedge core_clk)
    oscRunning <= !srcAny;
  // init takes DELAY edges after the start pulse; any reset wipes it
  always_ff @(posedge core_clk)
  begin
    if (srcAny)
    begin
      cnt           <= 0;
      flashInitDone <= 1'b0;
    end
    else if (flashInitStart)
      cnt <= DELAY;
    else if (cnt != 0)
    begin
      cnt           <= cnt - 1;
      flashInitDone <= (cnt == 1);
    end
  end
  // word not valid before init ends, so show a wrong one
  assign flashProtectWord = flashInitDone ? protWord : ~protWord;
endmodule // rbcp_flash_model

// *** bench/rbcp_reset_ctrl_assertions.sv ***
// checker on the top ports of the reset sequencer
module rbcp_reset_ctrl_assertions #(
  parameter int WAKE_CYCLES = 256
) (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        extResetPinN,
  input wire logic        watchdogReset,
  input wire logic        porReset,
  input wire logic        brownoutUpper,
  input wire logic        brownoutLower,
  input wire logic        oscRunning,
  input wire logic        flashInitDone,
  input wire logic        ispCmdValid,
  input wire logic        iapReq,
  input wire logic        coreReset,
  input wire logic        periphReset,
  input wire logic [31:0] bootFetchAddr,
  input wire logic        brownoutIrq,
  input wire logic        ispActive,
  input wire logic        ispGrant,
  input wire logic        ispDeny,
  input wire logic        iapGrant,
  input wire logic        flashInitStart
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] quietCnt;  // edges since last source, saturating
  wire         srcAny = porReset | watchdogReset | ~extResetPinN | brownoutLower;
  // count quiet edges so early release is caught
  always_ff @(posedge core_clk)
  begin
    if (rst || srcAny)
      quietCnt <= '0;
    else if (quietCnt != 16'hFFFF)
      quietCnt <= quietCnt + 16'h0001;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_source_forces_reset: assert property (srcAny |-> coreReset)
    else $error("reset source active but core not held");
  a_wake_count_held: assert property ($fell(coreReset) |-> quietCnt >= WAKE_CYCLES + 2)
    else $error("core released before wake count");
  a_release_conditions: assert property ($fell(coreReset) |-> flashInitDone && oscRunning && extResetPinN)
    else $error("core released with a condition missing");
  a_periph_under_core: assert property (coreReset |-> periphReset)
    else $error("peripherals out of reset before core");
  a_fetch_from_zero: assert property (!coreReset |-> bootFetchAddr == 32'h00000000)
    else $error("boot fetch address not zero");
  a_irq_tracks_bod: assert property (brownoutUpper [*4] |-> brownoutIrq)
    else $error("brownout interrupt missing");
  a_irq_clears: assert property (!brownoutUpper [*4] |-> !brownoutIrq)
    else $error("brownout interrupt stuck");
  a_iap_always: assert property (iapReq |=> iapGrant)
    else $error("firmware programming call refused");
  a_isp_one_answer: assert property (ispCmdValid |=> ispGrant ^ ispDeny)
    else $error("programming command not answered once");
  a_isp_idle_quiet: assert property (!ispCmdValid |=> !(ispGrant || ispDeny))
    else $error("programming answer without command");
  a_inactive_denied: assert property (ispCmdValid && !ispActive |=> ispDeny)
    else $error("command granted while programming inactive");
  a_apb_zero_wait: assert property (psel && penable |-> pready)
    else $error("bus access not answered at once");
  a_apb_unmapped: assert property (psel && penable && paddr > 8'h08 |-> pslverr)
    else $error("unmapped access without error");
  a_start_single_pulse: assert property (flashInitStart |-> coreReset ##1 !flashInitStart)
    else $error("flash init start not a single pulse under reset");
endmodule // rbcp_reset_ctrl_assertions

bind rbcp_reset_ctrl rbcp_reset_ctrl_assertions #(.WAKE_CYCLES(WAKE_CYCLES)) u_chk (
  .core_clk, .rst, .psel, .penable, .paddr, .pready, .pslverr, .extResetPinN,
  .watchdogReset, .porReset, .brownoutUpper, .brownoutLower, .oscRunning,
  .flashInitDone, .ispCmdValid, .iapReq, .coreReset, .periphReset, .bootFetchAddr,
  .brownoutIrq, .ispActive, .ispGrant, .ispDeny, .iapGrant, .flashInitStart
);

// *** bench/reset_brownout_and_code_protect_tb_top.sv ***
`include "rbcp_map.svh"
module reset_brownout_and_code_protect_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [31:0] w;
    logic        pinN;
    logic [3:0]  cmd;
    logic [7:0]  sec;
    logic        gr;
    logic [1:0]  lv;
  } rbcp_row_t;
  // flash word, pin, command, sector, grant, level
  rbcp_row_t rows [10] = '{
    '{32'h00000000, 1'b0, `RBCP_CMD_READ, 8'h00, 1'b1, 2'h0},
    '{32'hFFFFFFFF, 1'b0, `RBCP_CMD_WRITE, 8'h00, 1'b1, 2'h0},
    '{`RBCP_PAT_ONE, 1'b0, `RBCP_CMD_WRITE, 8'h00, 1'b0, 2'h1},
    '{`RBCP_PAT_ONE, 1'b0, `RBCP_CMD_ERASE_SEC, 8'h05, 1'b1, 2'h1},
    '{`RBCP_PAT_ONE, 1'b0, `RBCP_CMD_ERASE_ALL, 8'h00, 1'b0, 2'h1},
    '{`RBCP_PAT_ONE, 1'b0, `RBCP_CMD_GO, 8'h00, 1'b1, 2'h1},
    '{`RBCP_PAT_TWO, 1'b0, `RBCP_CMD_WRITE, 8'h01, 1'b0, 2'h2},
    '{`RBCP_PAT_TWO, 1'b0, `RBCP_CMD_ERASE_ALL, 8'h00, 1'b1, 2'h2},
    '{`RBCP_PAT_TWO, 1'b1, `RBCP_CMD_READ, 8'h00, 1'b0, 2'h2},
    '{`RBCP_PAT_THREE, 1'b0, `RBCP_CMD_READ, 8'h00, 1'b0, 2'h3}};
  logic        core_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        extResetPinN = 1'b1, watchdogReset = 1'b0, porReset = 1'b0;
  logic        brownoutUpper = 1'b0, brownoutLower = 1'b0, progEntryPinN = 1'b1;
  logic        ispCmdValid = 1'b0, iapReq = 1'b0, oscRunning, flashInitDone, pready, pslverr;
  logic        coreReset, periphReset, flashInitStart, bootMapActive, brownoutIrq;
  logic        jtagEnable, ispActive, ispGrant, ispDeny, iapGrant;
  logic [3:0]  ispCmd = 4'h0;
  logic [7:0]  paddr = 8'h00, ispSector = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, bootFetchAddr, flashProtectWord, protWord = 32'h0;
  int          mismatches = 0, n_compared = 0;
  // sequencer with a short wake count
  rbcp_reset_ctrl #(.WAKE_CYCLES(4)) dut (
    .core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .extResetPinN, .watchdogReset, .porReset, .brownoutUpper, .brownoutLower,
    .oscRunning, .flashInitDone, .flashProtectWord, .progEntryPinN, .ispCmdValid, .ispCmd,
    .ispSector, .iapReq, .coreReset, .periphReset, .flashInitStart, .bootFetchAddr,
    .bootMapActive, .brownoutIrq, .jtagEnable, .ispActive, .ispGrant, .ispDeny, .iapGrant);
  // flash and oscillator partner
  rbcp_flash_model #(.DELAY(3)) u_flash (
    .core_clk, .flashInitStart, .protWord, .oscRunning, .flashInitDone, .flashProtectWord,
    .srcAny(rst | porReset | watchdogReset | ~extResetPinN | brownoutLower));
  // 25 MHz clock
  initial
    forever #20 core_clk = ~core_clk;
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // one bus transfer, held until pready; a quiet edge follows
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  // one programming command; answer seen one edge later
  task automatic in_system_programming(input logic [3:0] c, input logic [7:0] s, output logic g);
    ispCmdValid <= 1'b1;
    ispCmd <= c;
    ispSector <= s;
    @(posedge core_clk);
    ispCmdValid <= 1'b0;
    @(posedge core_clk);
    g = ispGrant;
  endtask
  // wait for the core to run, bounded
  task automatic wait_run;
    int n;
    n = 0;
    while (coreReset !== 1'b0 && n < 100)
    begin
      @(posedge core_clk);
      n++;
    end
    chk(coreReset, 32'h0);
    chk(periphReset, 32'h0);
    chk(bootFetchAddr, `RBCP_BOOT_ADDR);
  endtask
  // watchdog reboot with a new flash word and pin level
  task automatic boot(input logic [31:0] w, input logic pinN);
    watchdogReset <= 1'b1;
    protWord <= w;
    progEntryPinN <= pinN;
    repeat (2) @(posedge core_clk);
    watchdogReset <= 1'b0;
    wait_run();
  endtask
  // hang guard
  initial
  begin
    repeat (5000) @(posedge core_clk);
    mismatches++;
    wrap_up();
  end
  // main sequence
  initial
  begin
    logic [31:0] q;
    logic        e, g;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    porReset <= 1'b1;
    extResetPinN <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk(coreReset, 32'h1);
    porReset <= 1'b0;
    extResetPinN <= 1'b1;
    wait_run();
    apb(1'b0, `RBCP_OFS_CAUSE, 32'h0, q, e);
    chk(q[3:0], 32'h5);
    apb(1'b1, `RBCP_OFS_CAUSE, 32'hF, q, e);
    apb(1'b0, `RBCP_OFS_CAUSE, 32'h0, q, e);
    chk(q, 32'h0);
    apb(1'b0, 8'h0C, 32'h0, q, e);
    chk(q, 32'h0);
    chk(e, 32'h1);
    chk(bootMapActive, 32'h1);
    apb(1'b1, `RBCP_OFS_CTRL, 32'h2, q, e);
    chk(bootMapActive, 32'h0);
    // each row boots a level and tries one command
    foreach (rows[i])
    begin
      boot(rows[i].w, rows[i].pinN);
      apb(1'b0, `RBCP_OFS_STATUS, 32'h0, q, e);
      chk(q[3:2], rows[i].lv);
      chk(jtagEnable, rows[i].lv == 2'h0);
      in_system_programming(rows[i].cmd, rows[i].sec, g);
      chk(g, rows[i].gr);
    end
    // level three: pin ignored, firmware paths still open
    chk(ispActive, 32'h0);
    iapReq <= 1'b1;
    @(posedge core_clk);
    iapReq <= 1'b0;
    @(posedge core_clk);
    chk(iapGrant, 32'h1);
    apb(1'b1, `RBCP_OFS_CTRL, 32'h1, q, e);
    // mode register follows the re-entry flag one edge later
    @(posedge core_clk);
    chk(ispActive, 32'h1);
    in_system_programming(`RBCP_CMD_READ, 8'h00, g);
    chk(g, 32'h1);
    // level two: write only after a full erase
    boot(`RBCP_PAT_TWO, 1'b0);
    in_system_programming(`RBCP_CMD_ERASE_ALL, 8'h00, g);
    in_system_programming(`RBCP_CMD_WRITE, 8'h03, g);
    chk(g, 32'h1);
    // upper brownout: interrupt level and status bit
    brownoutUpper <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk(brownoutIrq, 32'h1);
    apb(1'b0, `RBCP_OFS_STATUS, 32'h0, q, e);
    chk(q[0], 32'h1);
    brownoutUpper <= 1'b0;
    // lower brownout hands over to power-on hold
    brownoutLower <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk(coreReset, 32'h1);
    porReset <= 1'b1;
    brownoutLower <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk(coreReset, 32'h1);
    porReset <= 1'b0;
    wait_run();
    apb(1'b0, `RBCP_OFS_CAUSE, 32'h0, q, e);
    chk(q[3], 32'h1);
    wrap_up();
  end
endmodule // reset_brownout_and_code_protect_tb_top
